// ==== csiu_top.sv ====
// csiu_top: counter and status-register instruction unit of a program sequencer.
// assumes microcode memory drives i_instr each cycle and a host shares the
// 16-bit data port; the flag pin is asynchronous and synchronised here.
`timescale 1ns/1ps

// Behaviour
// RULE1 - condition field: 00 always, 01 flag low, 10 flag high, 11 sign
// RULE2 - two-bit index selects one of four counters
// RULE3 - clear-sign opcode clears sign bit and underflow interrupt latch
// RULE4 - any decrement copies counter msb before decrement into sign bit
// RULE5 - underflow interrupt raised when sign rises; only clear-sign clears it (code raises it only when a decrement raises the sign)
// RULE6 - unconditional decrement of selected counter
// RULE7 - conditional decrement of counter zero; else it holds
// RULE8 - sign condition tests stored sign bit; interrupt lags one decrement (code raises it in the same step as the sign)
// RULE9 - pop stack entry into counter, then decrement stack pointer
// RULE10 - increment stack pointer, then push counter into that entry
// RULE11 - set-sign opcode sets sign bit
// RULE12 - load selected counter from data port
// RULE13 - pop stack entry into status register, then decrement pointer
// RULE14 - increment pointer, then push status register
// RULE15 - drive status register onto data port
// RULE16 - host presents value; status register loaded from data port
// RULE17 - address port outputs incremented program counter each instruction
// RULE18 - counters and stack entries are sixteen bits wide
module csiu_top #(
  parameter int DATA_W = csiu_pkg::CSIU_DATA_W,
  parameter int SS_DEPTH = csiu_pkg::CSIU_SS_DEPTH
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // instruction port
  input wire logic [csiu_pkg::CSIU_OP_W-1:0] i_instr,
  input wire logic i_flag,
  // data port, split into in, out and enable
  input wire logic [DATA_W-1:0] i_data,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe,
  // address port and state
  output logic [DATA_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_status,
  output logic o_underflow_irq
);
  import csiu_pkg::*;

  localparam int SSP_W = $clog2(SS_DEPTH);

  // flag pin synchroniser; first stage read only by the second
  logic flag_meta_q;
  logic flag_sync_q;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_meta_q <= 1'b0;
      flag_sync_q <= 1'b0;
    end else begin
      flag_meta_q <= i_flag;
      flag_sync_q <= flag_meta_q;
    end
  end

  // state
  logic [DATA_W-1:0] cnt_q [CSIU_NUM_CNT]; // see RULE18
  logic [DATA_W-1:0] ss_q [SS_DEPTH]; // see RULE18
  logic [SSP_W-1:0] ssp_q;
  logic [DATA_W-1:0] status_q;
  logic [DATA_W-1:0] pc_q;
  logic irq_q;
  logic [DATA_W-1:0] dout_q;
  logic oe_q;

  // decode
  csiu_dec_if dec_bus ();
  csiu_decoder u_dec (
    .i_op(i_instr),
    .dec(dec_bus)
  );

  wire sign_now = status_q[CSIU_SIGN_BIT];
  logic cond_true;
  csiu_cond u_cond (
    .i_cc(dec_bus.cc),
    .i_flag(flag_sync_q),
    .i_sign(sign_now),
    .o_true(cond_true)
  );

  // selection and derived values
  wire csiu_cmd_t cmd = dec_bus.cmd;
  wire [1:0] idx = dec_bus.idx;
  wire do_dec = (cmd == CSIU_CMD_DEC) ||
                ((cmd == CSIU_CMD_COND_DEC) && cond_true); // see RULE6, see RULE7
  // conditional decrement always targets counter zero
  wire [1:0] dec_idx = (cmd == CSIU_CMD_COND_DEC) ? 2'd0 : idx; // see RULE7
  wire [DATA_W-1:0] dec_src = cnt_q[dec_idx];
  wire dec_msb = dec_src[DATA_W-1];
  wire [DATA_W-1:0] dec_val = dec_src - 1'b1;
  wire do_pop = (cmd == CSIU_CMD_POP_CNT) || (cmd == CSIU_CMD_POP_SR);
  wire do_push = (cmd == CSIU_CMD_PUSH_CNT) || (cmd == CSIU_CMD_PUSH_SR);
  wire [SSP_W-1:0] ssp_inc = ssp_q + 1'b1;
  wire [DATA_W-1:0] ss_top = ss_q[ssp_q];
  wire [DATA_W-1:0] push_val = (cmd == CSIU_CMD_PUSH_SR) ? status_q : cnt_q[idx];

  // status register next value; later clauses take priority
  logic [DATA_W-1:0] status_d;
  always_comb begin
    status_d = status_q;
    if (do_dec) status_d[CSIU_SIGN_BIT] = dec_msb; // see RULE4
    case (cmd)
      CSIU_CMD_CLR_SIGN: status_d[CSIU_SIGN_BIT] = 1'b0; // see RULE3
      CSIU_CMD_SET_SIGN: status_d[CSIU_SIGN_BIT] = 1'b1; // see RULE11
      CSIU_CMD_POP_SR: status_d = ss_top; // see RULE13
      CSIU_CMD_WRITE_SR: status_d = i_data; // see RULE16
      default: ;
    endcase
  end

  // underflow latch: a sign rise on a decrement sets it, clear-sign clears it, set wins.
  // for the conditional decrement too it sets in the same step as the sign, with no lag.
  wire sign_rise = status_d[CSIU_SIGN_BIT] & ~sign_now & do_dec; // see RULE5, see RULE8
  wire irq_d = sign_rise | (irq_q & (cmd != CSIU_CMD_CLR_SIGN)); // see RULE3, see RULE5

  // counters
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < CSIU_NUM_CNT; k++) cnt_q[k] <= CSIU_CNT_RST;
    end else begin
      if (do_dec) cnt_q[dec_idx] <= dec_val; // see RULE6
      if (cmd == CSIU_CMD_POP_CNT) cnt_q[idx] <= ss_top; // see RULE9
      if (cmd == CSIU_CMD_LOAD_CNT) cnt_q[idx] <= i_data; // see RULE12
    end
  end

  // subroutine stack; push writes the entry after the pointer advances
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < SS_DEPTH; k++) ss_q[k] <= {DATA_W{1'b0}};
    end else if (do_push) begin
      ss_q[ssp_inc] <= push_val; // see RULE10, see RULE14
    end
  end

  // stack pointer wraps silently; nothing checks for overflow
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ssp_q <= SSP_W'(CSIU_SSP_RST);
    end else if (do_push) begin
      ssp_q <= ssp_inc; // see RULE10, see RULE14
    end else if (do_pop) begin
      ssp_q <= ssp_q - 1'b1; // see RULE9, see RULE13
    end
  end

  // status, interrupt latch, program counter
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_q <= CSIU_STATUS_RST;
      irq_q <= 1'b0;
      pc_q <= CSIU_PC_RST;
    end else begin
      status_q <= status_d;
      irq_q <= irq_d;
      pc_q <= pc_q + 1'b1; // see RULE17
    end
  end

  // data port drive: status value shown the cycle after the read opcode
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dout_q <= {DATA_W{1'b0}};
      oe_q <= 1'b0;
    end else begin
      oe_q <= (cmd == CSIU_CMD_READ_SR); // see RULE15
      dout_q <= (cmd == CSIU_CMD_READ_SR) ? status_q : {DATA_W{1'b0}}; // see RULE15
    end
  end

  assign o_data = dout_q;
  assign o_data_oe = oe_q;
  assign o_addr = pc_q; // see RULE17
  assign o_status = status_q;
  assign o_underflow_irq = irq_q;
endmodule

// ==== csiu_pkg.sv ====
// csiu_pkg: opcodes, field positions, widths and reset values for the
// counter and status instruction unit.
// assumes a single 100 MHz clock domain; no bus, registers reached by opcodes.
package csiu_pkg;
  localparam int CSIU_DATA_W = 16;
  localparam int CSIU_OP_W = 7;
  localparam int CSIU_NUM_CNT = 4;
  localparam int CSIU_SS_DEPTH = 16;
  localparam int CSIU_SSP_W = 4;
  // whole-opcode instructions
  localparam logic [6:0] CSIU_OP_CLEAR_SIGN = 7'h14;
  localparam logic [6:0] CSIU_OP_SET_SIGN = 7'h34;
  localparam logic [6:0] CSIU_OP_POP_STATUS = 7'h22;
  localparam logic [6:0] CSIU_OP_PUSH_STATUS = 7'h21;
  localparam logic [6:0] CSIU_OP_READ_STATUS = 7'h2E;
  localparam logic [6:0] CSIU_OP_WRITE_STATUS = 7'h1C;
  // opcodes with a counter index in bits 1:0 (upper five bits compared)
  localparam logic [4:0] CSIU_OP_DEC_CNT = 5'h0C;
  localparam logic [4:0] CSIU_OP_POP_CNT = 5'h06;
  localparam logic [4:0] CSIU_OP_PUSH_CNT = 5'h02;
  localparam logic [4:0] CSIU_OP_LOAD_CNT = 5'h0E;
  // conditional decrement: 101 cc 00
  localparam logic [2:0] CSIU_OP_COND_DEC_HI = 3'h5;
  localparam logic [1:0] CSIU_OP_COND_DEC_LO = 2'h0;
  // condition select codes
  localparam logic [1:0] CSIU_CC_ALWAYS = 2'h0;
  localparam logic [1:0] CSIU_CC_NOT_FLAG = 2'h1;
  localparam logic [1:0] CSIU_CC_FLAG = 2'h2;
  localparam logic [1:0] CSIU_CC_SIGN = 2'h3;
  // field positions
  localparam int CSIU_SIGN_BIT = 1;
  localparam int CSIU_CC_LSB = 2;
  localparam int CSIU_CNT_MSB = CSIU_DATA_W - 1;
  // reset values
  localparam logic [15:0] CSIU_STATUS_RST = 16'h0000;
  localparam logic [15:0] CSIU_CNT_RST = 16'h0000;
  localparam logic [15:0] CSIU_PC_RST = 16'h0000;
  localparam logic [3:0] CSIU_SSP_RST = 4'h0;

  typedef enum logic [3:0] {
    CSIU_CMD_NONE = 4'b0000,
    CSIU_CMD_CLR_SIGN = 4'b0001,
    CSIU_CMD_SET_SIGN = 4'b0010,
    CSIU_CMD_DEC = 4'b0011,
    CSIU_CMD_COND_DEC = 4'b0100,
    CSIU_CMD_POP_CNT = 4'b0101,
    CSIU_CMD_PUSH_CNT = 4'b0110,
    CSIU_CMD_LOAD_CNT = 4'b0111,
    CSIU_CMD_POP_SR = 4'b1000,
    CSIU_CMD_PUSH_SR = 4'b1001,
    CSIU_CMD_READ_SR = 4'b1010,
    CSIU_CMD_WRITE_SR = 4'b1011
  } csiu_cmd_t;
endpackage

// ==== csiu_dec_if.sv ====
// csiu_dec_if: decoded instruction travelling from decoder to datapath.
// assumes both ends share the unit's clock.
`timescale 1ns/1ps
interface csiu_dec_if;
  import csiu_pkg::*;
  csiu_cmd_t cmd;
  logic [1:0] idx;
  logic [1:0] cc;
  modport dec (output cmd, output idx, output cc);
  modport dp (input cmd, input idx, input cc);
endinterface

// ==== csiu_decoder.sv ====
// csiu_decoder: turns a 7-bit opcode into a command, index and condition.
// assumes the opcode is already registered in the sequencer clock domain.
`timescale 1ns/1ps
module csiu_decoder (
  // opcode in
  input wire logic [6:0] i_op,
  // decoded command out
  csiu_dec_if.dec dec
);
  import csiu_pkg::*;

  wire [4:0] op_hi = i_op[6:2];
  wire [1:0] op_idx = i_op[1:0];
  wire is_cond = (i_op[6:4] == CSIU_OP_COND_DEC_HI) && (i_op[1:0] == CSIU_OP_COND_DEC_LO);

  // whole opcodes first; they never collide with the indexed groups
  always_comb begin
    dec.cmd = CSIU_CMD_NONE;
    if (i_op == CSIU_OP_CLEAR_SIGN) dec.cmd = CSIU_CMD_CLR_SIGN; // see RULE3
    else if (i_op == CSIU_OP_SET_SIGN) dec.cmd = CSIU_CMD_SET_SIGN; // see RULE11
    else if (i_op == CSIU_OP_POP_STATUS) dec.cmd = CSIU_CMD_POP_SR; // see RULE13
    else if (i_op == CSIU_OP_PUSH_STATUS) dec.cmd = CSIU_CMD_PUSH_SR; // see RULE14
    else if (i_op == CSIU_OP_READ_STATUS) dec.cmd = CSIU_CMD_READ_SR; // see RULE15
    else if (i_op == CSIU_OP_WRITE_STATUS) dec.cmd = CSIU_CMD_WRITE_SR; // see RULE16
    else if (op_hi == CSIU_OP_DEC_CNT) dec.cmd = CSIU_CMD_DEC; // see RULE6
    else if (op_hi == CSIU_OP_POP_CNT) dec.cmd = CSIU_CMD_POP_CNT; // see RULE9
    else if (op_hi == CSIU_OP_PUSH_CNT) dec.cmd = CSIU_CMD_PUSH_CNT; // see RULE10
    else if (op_hi == CSIU_OP_LOAD_CNT) dec.cmd = CSIU_CMD_LOAD_CNT; // see RULE12
    else if (is_cond) dec.cmd = CSIU_CMD_COND_DEC; // see RULE7
  end

  assign dec.idx = op_idx; // see RULE2
  assign dec.cc = i_op[CSIU_CC_LSB +: 2];
endmodule

// ==== csiu_cond.sv ====
// csiu_cond: evaluates the two-bit condition field of the conditional decrement.
// assumes the flag input is already synchronised to the clock.
`timescale 1ns/1ps
module csiu_cond (
  // condition inputs
  input wire logic [1:0] i_cc,
  input wire logic i_flag,
  input wire logic i_sign,
  // result
  output logic o_true
);
  import csiu_pkg::*;

  // sign tests the stored status bit, never the counter's own msb
  always_comb begin
    case (i_cc)
      CSIU_CC_ALWAYS: o_true = 1'b1; // see RULE1
      CSIU_CC_NOT_FLAG: o_true = ~i_flag; // see RULE1
      CSIU_CC_FLAG: o_true = i_flag; // see RULE1
      CSIU_CC_SIGN: o_true = i_sign; // see RULE1, see RULE8
      default: o_true = 1'b0;
    endcase
  end
endmodule

// ==== csiu_top_sva.sv ====
// csiu_top_sva: port-level checks for the counter and status instruction unit.
// assumes one clock domain; bound onto csiu_top below.
`timescale 1ns/1ps
module csiu_top_sva #(
  parameter int DATA_W = csiu_pkg::CSIU_DATA_W,
  parameter int SS_DEPTH = csiu_pkg::CSIU_SS_DEPTH
) (
  // clock, reset and instruction port
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [csiu_pkg::CSIU_OP_W-1:0] i_instr,
  input wire logic i_flag,
  // data port and state
  input wire logic [DATA_W-1:0] i_data,
  input wire logic [DATA_W-1:0] o_data,
  input wire logic o_data_oe,
  input wire logic [DATA_W-1:0] o_addr,
  input wire logic [DATA_W-1:0] o_status,
  input wire logic o_underflow_irq
);
  import csiu_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // push status, idle, pop status: the pop must hand back the pushed word
  sequence s_sr_round;
    i_instr == CSIU_OP_PUSH_STATUS ##1 i_instr == 7'h00 ##1 i_instr == CSIU_OP_POP_STATUS;
  endsequence
  AST_ADDR_STEP: assert property (1'b1 |=> o_addr == $past(o_addr) + 1'b1)
    else $error("address did not advance by one");
  AST_WRITE_SR: assert property (i_instr == CSIU_OP_WRITE_STATUS |=> o_status == $past(i_data))
    else $error("status not loaded from data port");
  AST_READ_SR: assert property (i_instr == CSIU_OP_READ_STATUS |=> o_data_oe && o_data == $past(o_status))
    else $error("status not driven on data port");
  AST_OE_ONLY_READ: assert property (i_instr != CSIU_OP_READ_STATUS |=> !o_data_oe)
    else $error("data port driven without a read");
  AST_SET_SIGN: assert property (i_instr == CSIU_OP_SET_SIGN |=> o_status[1])
    else $error("sign bit not set");
  AST_CLR_SIGN: assert property (i_instr == CSIU_OP_CLEAR_SIGN |=> !o_status[1] && !o_underflow_irq)
    else $error("sign or underflow latch not cleared");
  AST_IRQ_STICKY: assert property (o_underflow_irq && i_instr != CSIU_OP_CLEAR_SIGN |=> o_underflow_irq)
    else $error("underflow latch dropped without clear");
  AST_IRQ_RISE: assert property ($rose(o_underflow_irq) |-> $rose(o_status[1]))
    else $error("underflow raised without sign rising");
  AST_COND_SIGN_FALSE: assert property (i_instr == 7'h5C && !o_status[1] |=> $stable(o_status))
    else $error("sign-conditioned decrement taken on clear sign");
  AST_SR_ROUND: assert property (s_sr_round |=> o_status == $past(o_status, 3))
    else $error("status push and pop did not restore");
endmodule

bind csiu_top csiu_top_sva #(.DATA_W(DATA_W), .SS_DEPTH(SS_DEPTH)) u_sva (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_instr(i_instr), .i_flag(i_flag),
  .i_data(i_data), .o_data(o_data), .o_data_oe(o_data_oe), .o_addr(o_addr),
  .o_status(o_status), .o_underflow_irq(o_underflow_irq));

// ==== csiu_host_model.sv ====
// csiu_host_model: host logic on the shared 16-bit data port.
// assumes the device raises its enable only for a status read.
`timescale 1ns/1ps
module csiu_host_model #(
  parameter int DATA_W = 16
) (
  // host value and device side of the port
  input wire logic [DATA_W-1:0] i_host_val,
  input wire logic [DATA_W-1:0] i_dev_data,
  input wire logic i_dev_oe,
  // resolved wire level
  output logic [DATA_W-1:0] o_bus
);
  // host backs off while the device drives, so no contention on reads
  assign o_bus = i_dev_oe ? i_dev_data : i_host_val;
endmodule

// ==== csiu_top_tb_top.sv ====
// csiu_top_tb_top: self-checking bench with a reference model of the unit.
// assumes csiu_pkg, csiu_top and the host model are compiled first.
`timescale 1ns/1ps
module csiu_top_tb_top;
  import csiu_pkg::*;
  typedef struct packed {logic [6:0] op; logic [15:0] d; logic f;} csiu_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] instr = 7'h00;
  logic flag = 1'b0;
  logic [15:0] hval = 16'h0000;
  logic [15:0] bus, dout, addr, status, last_addr, st;
  logic oe, irq, irq_m;
  logic [15:0] cnt [4];
  logic [15:0] stk [16];
  logic [3:0] subroutine_stack_pointer;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  // flag of a conditional row matches the row before, since the pin is synchronised late
  csiu_row_t rows [40] = '{
    '{7'h38,16'h0002,1'b0}, '{7'h39,16'h0000,1'b0}, '{7'h3B,16'hA5C3,1'b0},
    '{7'h1C,16'hE05C,1'b0}, '{7'h2E,16'h0000,1'b0}, '{7'h34,16'h0000,1'b0},
    '{7'h2E,16'h0000,1'b0}, '{7'h14,16'h0000,1'b0}, '{7'h31,16'h0000,1'b0},
    '{7'h31,16'h0000,1'b0}, '{7'h03,16'h0000,1'b0}, '{7'h2E,16'h0000,1'b0},
    '{7'h14,16'h0000,1'b0}, '{7'h31,16'h0000,1'b0}, '{7'h14,16'h0000,1'b0},
    '{7'h50,16'h0000,1'b0}, '{7'h54,16'h0000,1'b0}, '{7'h58,16'h0000,1'b0},
    '{7'h5C,16'h0000,1'b0}, '{7'h34,16'h0000,1'b0}, '{7'h5C,16'h0000,1'b0},
    '{7'h00,16'h0000,1'b1}, '{7'h58,16'h0000,1'b1}, '{7'h54,16'h0000,1'b1},
    '{7'h14,16'h0000,1'b0}, '{7'h08,16'h0000,1'b0}, '{7'h09,16'h0000,1'b0},
    '{7'h0B,16'h0000,1'b0}, '{7'h22,16'h0000,1'b0}, '{7'h22,16'h0000,1'b0},
    '{7'h1A,16'h0000,1'b0}, '{7'h0A,16'h0000,1'b0}, '{7'h22,16'h0000,1'b0},
    '{7'h21,16'h0000,1'b0}, '{7'h22,16'h0000,1'b0}, '{7'h21,16'h0000,1'b0},
    '{7'h1C,16'h1234,1'b0}, '{7'h2E,16'h0000,1'b0}, '{7'h22,16'h0000,1'b0},
    '{7'h2E,16'h0000,1'b0}};

  csiu_top dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_instr(instr), .i_flag(flag),
    .i_data(bus), .o_data(dout), .o_data_oe(oe), .o_addr(addr), .o_status(status),
    .o_underflow_irq(irq));
  csiu_host_model #(.DATA_W(16)) host_u (.i_host_val(hval), .i_dev_data(dout),
    .i_dev_oe(oe), .o_bus(bus));

  // clock and hang guard
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic mreset();
    st = CSIU_STATUS_RST;
    subroutine_stack_pointer = CSIU_SSP_RST;
    irq_m = 1'b0;
    foreach (cnt[k]) cnt[k] = CSIU_CNT_RST;
  endtask

  // decrement copies the old msb into the sign and latches a rising sign
  task automatic dec(input logic [1:0] k);
    if (cnt[k][15] && !st[1]) irq_m = 1'b1;
    st[1] = cnt[k][15];
    cnt[k] = cnt[k] - 16'h0001;
  endtask

  task automatic model(input csiu_row_t r);
    logic [1:0] i;
    logic [1:0] c;
    i = r.op[1:0];
    c = r.op[3:2];
    if (r.op == CSIU_OP_CLEAR_SIGN) begin
      st[1] = 1'b0;
      irq_m = 1'b0;
    end else if (r.op == CSIU_OP_SET_SIGN) st[1] = 1'b1;
    else if (r.op[6:2] == CSIU_OP_DEC_CNT) dec(i);
    else if (r.op[6:4] == CSIU_OP_COND_DEC_HI && i == CSIU_OP_COND_DEC_LO) begin
      if (c == 2'h0 || (c == 2'h1 && !r.f) || (c == 2'h2 && r.f) || (c == 2'h3 && st[1]))
        dec(2'h0);
    end else if (r.op[6:2] == CSIU_OP_POP_CNT) begin
      cnt[i] = stk[subroutine_stack_pointer];
      subroutine_stack_pointer = subroutine_stack_pointer - 4'h1;
    end else if (r.op[6:2] == CSIU_OP_PUSH_CNT) begin
      subroutine_stack_pointer = subroutine_stack_pointer + 4'h1;
      stk[subroutine_stack_pointer] = cnt[i];
    end else if (r.op[6:2] == CSIU_OP_LOAD_CNT) cnt[i] = r.d;
    else if (r.op == CSIU_OP_POP_STATUS) begin
      st = stk[subroutine_stack_pointer];
      subroutine_stack_pointer = subroutine_stack_pointer - 4'h1;
    end else if (r.op == CSIU_OP_PUSH_STATUS) begin
      subroutine_stack_pointer = subroutine_stack_pointer + 4'h1;
      stk[subroutine_stack_pointer] = st;
    end else if (r.op == CSIU_OP_WRITE_STATUS) st = r.d;
  endtask

  // one instruction, then an idle cycle so it is taken exactly once
  task automatic run(input csiu_row_t r);
    logic [15:0] s;
    @(posedge clk);
    instr <= r.op;
    hval <= r.d;
    flag <= r.f;
    s = st;
    model(r);
    @(posedge clk);
    instr <= 7'h00;
    #1;
    chk(status, st);
    chk(16'(irq), 16'(irq_m));
    chk(addr, last_addr + 16'h0002);
    chk(16'(oe), 16'(r.op == CSIU_OP_READ_STATUS));
    if (r.op == CSIU_OP_READ_STATUS) chk(dout, s);
    last_addr = addr;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    #1;
    chk(status, 16'h0000);
    chk(addr, 16'h0000);
    @(posedge clk) rst_n <= 1'b1;
    mreset();
    #1 last_addr = addr;
    foreach (rows[k]) run(rows[k]);
    // reset in mid-run: status, latch, address, enable and counter zero must start over
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) #1;
    chk(status, 16'h0000);
    chk(16'(irq), 16'h0000);
    chk(addr, 16'h0000);
    chk(16'(oe), 16'h0000);
    @(posedge clk) rst_n <= 1'b1;
    mreset();
    #1 last_addr = addr;
    run('{7'h08, 16'h0000, 1'b0});
    run('{7'h22, 16'h0000, 1'b0});
    final_report();
  end
endmodule
